// ### verilog/per_exception_reporter.sv
`timescale 1ns/1ps
`default_nettype none
module per_exception_reporter (
  input  wire logic                          i_mclk,            // Core clock
  input  wire logic                          i_rst,             // Async reset, active high
  input  wire per_pkg::per_mode_t            i_mode,            // Operating mode
  input  wire logic [per_pkg::PER_ADDR_W-1:0] i_table_base,     // Descriptor table base
  input  wire logic                          i_if_flag,         // External interrupts unmasked
  input  wire logic                          i_ext_irq,         // External request pulse
  input  wire logic [per_pkg::PER_VEC_W-1:0] i_ext_vec,         // External vector
  input  wire logic                          i_ret_valid,       // Oldest instruction ready to retire
  input  wire logic [per_pkg::PER_ADDR_W-1:0] i_ret_pc,         // Its address
  input  wire logic [per_pkg::PER_ADDR_W-1:0] i_ret_next_pc,    // Address of the next one
  input  wire logic                          i_ret_exc,         // It raised an exception
  input  wire per_pkg::per_kind_t            i_ret_exc_kind,    // Fault, trap or abort
  input  wire logic [per_pkg::PER_VEC_W-1:0] i_ret_exc_vec,     // Exception vector
  input  wire logic                          i_ret_fp_exc,      // Floating-point condition
  input  wire logic                          i_ret_fp_masked,   // Condition masked
  input  wire logic                          i_ret_swint,       // Interrupt instruction
  input  wire logic [per_pkg::PER_VEC_W-1:0] i_ret_swint_vec,   // Its vector
  input  wire logic                          i_ret_sstep,       // Single-step condition
  input  wire logic                          i_ret_bkpt,        // Breakpoint match
  input  wire logic                          i_ret_task_switch, // Instruction is a task switch
  input  wire logic [per_pkg::PER_VEC_W-1:0] i_dbg_vec,         // Debug vector
  input  wire logic                          i_redirect_done,   // Pipeline now fetches handler
  output logic                               o_ret_commit,      // Retire the oldest instruction
  output logic                               o_ret_squash,      // Discard its partial state
  output logic                               o_evt_valid,       // Event delivered, one cycle
  output per_pkg::per_class_t                o_evt_class,       // Reporting class
  output per_pkg::per_src_t                  o_evt_src,         // Event source
  output logic [per_pkg::PER_VEC_W-1:0]      o_evt_vector,      // Event vector
  output logic [per_pkg::PER_ADDR_W-1:0]     o_evt_desc_addr,   // Descriptor entry address
  output logic [per_pkg::PER_ADDR_W-1:0]     o_evt_return_ptr,  // Saved return pointer
  output logic                               o_evt_tsw_update,  // Task-switch state updated
  output logic                               o_halt_fetch,      // Interrupted program stopped
  output logic                               o_fp_default,      // Apply default FP handling
  output logic                               o_ext_ack          // External request taken
);
  import per_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  per_state_t            st_reg, st_next;       // Reporter state
  logic                  pend_reg, pend_next;   // External request pending
  logic [PER_VEC_W-1:0]  pvec_reg, pvec_next;   // Pending external vector
  per_cls_if             cif ();                // Link to the classifier

  ////////////////////////////////////////////////////////////////////////////
  // Classifier hookup
  assign cif.clk       = i_mclk;
  assign cif.rst       = i_rst;
  assign cif.run       = (st_reg == PER_ST_RUN);
  assign cif.ret_valid = i_ret_valid;
  assign cif.exc       = i_ret_exc;
  assign cif.exc_kind  = i_ret_exc_kind;
  assign cif.exc_vec   = i_ret_exc_vec;
  assign cif.fp_exc    = i_ret_fp_exc;
  assign cif.fp_masked = i_ret_fp_masked;
  assign cif.swint     = i_ret_swint;
  assign cif.swint_vec = i_ret_swint_vec;
  assign cif.sstep     = i_ret_sstep;
  assign cif.bkpt      = i_ret_bkpt;
  assign cif.dbg_vec   = i_dbg_vec;
  assign cif.ext_pend  = pend_reg;
  assign cif.if_flag   = i_if_flag;
  assign cif.ext_vec   = pvec_reg;

  per_classify u_cls (
    .c (cif.cls_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire ext_take = cif.fire && (cif.src == PER_SRC_EXT);   // Pending request delivered
  wire is_bef   = cif.fire && (cif.cls == PER_CLS_BEFORE); // Instruction must not complete
  wire is_aft   = cif.fire && (cif.cls == PER_CLS_AFTER);  // Instruction completes first
  // Only the oldest instruction retires, and only while running
  assign o_ret_commit = cif.run && i_ret_valid && !is_bef && !(cif.fire && cif.cls == PER_CLS_IMPRECISE);
  // Faulting instruction leaves no state behind
  assign o_ret_squash = is_bef && !ext_take;
  // Stop the interrupted program while redirecting
  assign o_halt_fetch = (st_reg == PER_ST_REDIRECT);

  // Entry size follows mode; vector is the index in all modes
  wire [2:0] shamt = (i_mode == PER_MODE_REAL) ? PER_SHIFT_REAL :
                     (i_mode == PER_MODE_PROT) ? PER_SHIFT_PROT : PER_SHIFT_LONG;
  wire [PER_ADDR_W-1:0] desc_addr = i_table_base + (PER_ADDR_W'(cif.vec) << shamt);
  // Return pointer: boundary before or after the instruction
  wire [PER_ADDR_W-1:0] ret_ptr = is_aft ? i_ret_next_pc : i_ret_pc;
  // Task-switch updates only outside long mode
  wire tsw_upd = is_aft && i_ret_task_switch && (i_mode != PER_MODE_LONG);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PER_ST_RUN: begin
        if (cif.fire) begin
          st_next = PER_ST_REDIRECT;       // Transfer control
        end
      end
      PER_ST_REDIRECT: begin
        if (i_redirect_done) begin
          st_next = PER_ST_RUN;            // Handler fetch under way
        end
      end
      default: st_next = PER_ST_RUN;
    endcase
  end

  // Requests latch whatever the instruction stream does; a new one wins over delivery
  always_comb begin
    pend_next = pend_reg;
    pvec_next = pvec_reg;
    if (ext_take) begin
      pend_next = 1'b0;                    // Delivered
    end
    if (i_ext_irq && (!pend_reg || ext_take)) begin
      pend_next = 1'b1;                    // New request held
      pvec_next = i_ext_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg   <= PER_ST_RUN;
      pend_reg <= 1'b0;
      pvec_reg <= PER_VEC_RST;
    end else begin
      st_reg   <= st_next;
      pend_reg <= pend_next;
      pvec_reg <= pvec_next;
    end
  end

  // Event report registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_evt_valid      <= 1'b0;
      o_evt_class      <= PER_CLS_NONE;
      o_evt_src        <= PER_SRC_NONE;
      o_evt_vector     <= PER_VEC_RST;
      o_evt_desc_addr  <= PER_ADDR_RST;
      o_evt_return_ptr <= PER_ADDR_RST;
      o_evt_tsw_update <= 1'b0;
      o_fp_default     <= 1'b0;
      o_ext_ack        <= 1'b0;
    end else begin
      o_evt_valid      <= cif.fire;
      o_fp_default     <= cif.fp_default;
      o_ext_ack        <= ext_take;
      o_evt_tsw_update <= tsw_upd;
      if (cif.fire) begin
        o_evt_class      <= cif.cls;
        o_evt_src        <= cif.src;
        o_evt_vector     <= cif.vec;
        o_evt_desc_addr  <= desc_addr;
        o_evt_return_ptr <= ret_ptr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_take;
    (st_reg == PER_ST_RUN) && cif.fire;
  endsequence
  sequence s_deliver;
    o_evt_valid && o_halt_fetch && !o_ret_commit;
  endsequence

  a_evt_delivery:
    assert property (s_take |=> s_deliver)
    else $error("event taken but not delivered");
  a_squash_nocommit:
    assert property (o_ret_squash |-> !o_ret_commit ##1 o_evt_class == PER_CLS_BEFORE)
    else $error("faulting instruction committed");
  a_pend_masked:
    assert property (pend_reg && !i_if_flag |=> pend_reg && !o_ext_ack)
    else $error("masked external request lost");
  a_ext_latch:
    assert property (i_ext_irq && !pend_reg |=> pend_reg && pvec_reg == $past(i_ext_vec))
    else $error("external request not accepted");
  a_ptr_before:
    assert property (s_take ##0 (cif.cls == PER_CLS_BEFORE) |=> o_evt_return_ptr == $past(i_ret_pc))
    else $error("before-boundary pointer wrong");
  a_ptr_after:
    assert property (s_take ##0 (cif.cls == PER_CLS_AFTER)
                     |-> o_ret_commit ##1 o_evt_return_ptr == $past(i_ret_next_pc))
    else $error("after-boundary instruction not completed");
  a_desc_index:
    assert property (s_take ##0 (i_mode == PER_MODE_LONG)
                     |=> o_evt_desc_addr == $past(i_table_base) + (PER_ADDR_W'($past(cif.vec)) << PER_SHIFT_LONG))
    else $error("descriptor address wrong in long mode");
  a_long_notsw:
    assert property (o_evt_tsw_update |-> $past(i_mode) != PER_MODE_LONG)
    else $error("task switch update in long mode");
  a_tsw_update:
    assert property (s_take ##0 (cif.cls == PER_CLS_AFTER && i_ret_task_switch && i_mode == PER_MODE_PROT)
                     |=> o_evt_tsw_update)
    else $error("task switch update missing");
  a_oldest_only:
    assert property (o_ret_commit |-> (i_ret_valid && !o_halt_fetch) ##1 (!o_evt_valid || o_evt_class == PER_CLS_AFTER))
    else $error("commit outside oldest boundary");
endmodule // per_exception_reporter
`default_nettype wire

// ### shared/per_pkg.sv
`default_nettype none
package per_pkg;
  // Widths
  localparam int PER_VEC_W  = 8;                  // Event vector number width
  localparam int PER_ADDR_W = 64;                 // Instruction and table address width
  // Descriptor entry size as a left shift of the vector, per operating mode
  localparam logic [2:0] PER_SHIFT_REAL = 3'h2;   // Four-byte entries
  localparam logic [2:0] PER_SHIFT_PROT = 3'h3;   // Eight-byte entries
  localparam logic [2:0] PER_SHIFT_LONG = 3'h4;   // Sixteen-byte entries
  // Reset values
  localparam logic [PER_VEC_W-1:0]  PER_VEC_RST  = 8'h00;
  localparam logic [PER_ADDR_W-1:0] PER_ADDR_RST = 64'h0;
  // Operating mode of the core
  typedef enum logic [1:0] {PER_MODE_REAL, PER_MODE_PROT, PER_MODE_LONG} per_mode_t;
  // Reporting class of a delivered event
  typedef enum logic [1:0] {PER_CLS_NONE, PER_CLS_BEFORE, PER_CLS_AFTER, PER_CLS_IMPRECISE} per_class_t;
  // Kind of exception flagged by the retiring instruction
  typedef enum logic [1:0] {PER_KIND_FAULT, PER_KIND_TRAP, PER_KIND_ABORT} per_kind_t;
  // Source of a delivered event
  typedef enum logic [2:0] {PER_SRC_NONE, PER_SRC_EXC, PER_SRC_DEBUG, PER_SRC_SWINT, PER_SRC_EXT} per_src_t;
  // Reporter control states
  typedef enum logic {PER_ST_RUN, PER_ST_REDIRECT} per_state_t;
endpackage
`default_nettype wire

// ### shared/per_cls_if.sv
`timescale 1ns/1ps
`default_nettype none
interface per_cls_if;
  import per_pkg::*;
  logic                 clk;        // Core clock
  logic                 rst;        // Core reset, active high
  logic                 run;        // Reporter is accepting boundaries
  logic                 ret_valid;  // Oldest uncompleted instruction present
  logic                 exc;        // Instruction raised an exception
  per_kind_t            exc_kind;   // Fault, trap or abort
  logic [PER_VEC_W-1:0] exc_vec;    // Exception vector
  logic                 fp_exc;     // Floating-point exception condition
  logic                 fp_masked;  // That condition is masked
  logic                 swint;      // Interrupt instruction
  logic [PER_VEC_W-1:0] swint_vec;  // Its vector
  logic                 sstep;      // Single-step condition
  logic                 bkpt;       // Address breakpoint match
  logic [PER_VEC_W-1:0] dbg_vec;    // Debug vector
  logic                 ext_pend;   // External request pending
  logic                 if_flag;    // External interrupts unmasked
  logic [PER_VEC_W-1:0] ext_vec;    // Pending external vector
  logic                 fire;       // Event is taken at this boundary
  per_class_t           cls;        // Reporting class
  per_src_t             src;        // Event source
  logic [PER_VEC_W-1:0] vec;        // Event vector
  logic                 fp_default; // Masked floating-point, default handling
  modport main (output clk, rst, run, ret_valid, exc, exc_kind, exc_vec, fp_exc, fp_masked, swint,
                swint_vec, sstep, bkpt, dbg_vec, ext_pend, if_flag, ext_vec,
                input fire, cls, src, vec, fp_default);
  modport cls_side (input clk, rst, run, ret_valid, exc, exc_kind, exc_vec, fp_exc, fp_masked, swint,
                    swint_vec, sstep, bkpt, dbg_vec, ext_pend, if_flag, ext_vec,
                    output fire, cls, src, vec, fp_default);
endinterface
`default_nettype wire

// ### verilog/per_classify.sv
`timescale 1ns/1ps
`default_nettype none
module per_classify (
  per_cls_if.cls_side c
);
  import per_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode
  wire at_bnd    = c.run && c.ret_valid;                            // Boundary is open
  wire take_ext  = at_bnd && c.ext_pend && c.if_flag;               // Unmasked external request
  wire take_abrt = at_bnd && c.exc && (c.exc_kind == PER_KIND_ABORT); // Abort
  wire fp_raise  = c.fp_exc && !c.fp_masked;                         // Unmasked floating-point
  wire take_flt  = at_bnd && ((c.exc && (c.exc_kind == PER_KIND_FAULT)) || fp_raise); // Fault
  wire take_bkpt = at_bnd && c.bkpt;                                 // Breakpoint before boundary
  wire take_trap = at_bnd && c.exc && (c.exc_kind == PER_KIND_TRAP);  // Trap
  wire take_sw   = at_bnd && c.swint;                                // Interrupt instruction
  wire take_ss   = at_bnd && c.sstep;                                // Single step after boundary
  wire any_bef   = take_flt || take_bkpt;                            // Reported before instruction
  wire any_aft   = take_trap || take_sw || take_ss;                  // Reported after instruction

  ////////////////////////////////////////////////////////////////////////////
  // Priority selection
  assign c.fire = take_ext || take_abrt || any_bef || any_aft;
  // Masked floating-point gets default handling, no mechanism, unless an event fires at the same boundary
  assign c.fp_default = at_bnd && c.fp_exc && c.fp_masked && !c.fire;
  // External requests stop the instruction before it starts, so before-class
  assign c.cls = take_ext  ? PER_CLS_BEFORE    :
                 take_abrt ? PER_CLS_IMPRECISE :  // No restart guarantee
                 any_bef   ? PER_CLS_BEFORE    :  // Faulting instruction squashed
                 any_aft   ? PER_CLS_AFTER     :  // Causing instruction completes
                             PER_CLS_NONE;
  // Interrupt instructions and debug conditions are synchronous events
  assign c.src = take_ext              ? PER_SRC_EXT   :
                 (take_abrt||take_flt) ? PER_SRC_EXC   :
                 take_bkpt             ? PER_SRC_DEBUG :
                 take_trap             ? PER_SRC_EXC   :
                 take_sw               ? PER_SRC_SWINT :
                 take_ss               ? PER_SRC_DEBUG :
                                         PER_SRC_NONE;
  assign c.vec = (c.src == PER_SRC_EXT)   ? c.ext_vec   :
                 (c.src == PER_SRC_SWINT) ? c.swint_vec :
                 (c.src == PER_SRC_DEBUG) ? c.dbg_vec   :
                                            c.exc_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge c.clk); endclocking
  default disable iff (c.rst);

  a_swint_after_bnd:
    assert property (at_bnd && c.swint && !c.ext_pend && !c.exc && !c.bkpt && !fp_raise
                     |-> c.fire && c.cls == PER_CLS_AFTER && c.vec == c.swint_vec)
    else $error("interrupt instruction not reported after boundary");
  a_debug_sync:
    assert property (at_bnd && (c.sstep || c.bkpt) |-> c.fire && c.cls != PER_CLS_NONE)
    else $error("debug condition not raised as event");
  a_abort_imprecise:
    assert property (take_abrt && !take_ext |-> c.cls == PER_CLS_IMPRECISE)
    else $error("abort not classed imprecise");
endmodule // per_classify
`default_nettype wire

// ### test/per_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: pipeline redirect responder and external interrupt source
module per_pipe_model (
  input  wire logic       i_mclk,          // Core clock
  input  wire logic       i_rst,           // Async reset, active high
  input  wire logic       i_halt_fetch,    // Reporter waits for redirect
  input  wire logic [3:0] i_dly,           // Cycles before redirect is reported
  input  wire logic       i_ext_req,       // Bench asks for one request
  input  wire logic [7:0] i_req_vec,       // Vector of that request
  output logic            o_redirect_done, // Handler fetch started
  output logic            o_ext_irq,       // External request pulse
  output logic [7:0]      o_ext_vec        // Vector, valid with the pulse only
);
  logic [3:0] cnt_reg; // Cycles spent in redirect
  ////////////////////////////////////////////////////////////////////////////
  // Redirect answers promptly or slowly, one pulse per redirect
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg         <= 4'h0;
      o_redirect_done <= 1'b0;
    end else begin
      cnt_reg         <= (!i_halt_fetch || o_redirect_done) ? 4'h0 : cnt_reg + 4'h1;
      o_redirect_done <= i_halt_fetch && !o_redirect_done && (cnt_reg == i_dly);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Request raised apart from instruction flow; vector line churns when idle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ext_irq <= 1'b0;
      o_ext_vec <= 8'h00;
    end else begin
      o_ext_irq <= i_ext_req;
      o_ext_vec <= i_ext_req ? i_req_vec : ~o_ext_vec;
    end
  end
endmodule // per_pipe_model
`default_nettype wire

// ### test/test_precise_exception_reporter.sv
`timescale 1ns/1ps
`default_nettype none
module test_precise_exception_reporter;
  import per_pkg::*;
  localparam logic [63:0] BASE = 64'h0000_0000_0010_0000; // Table base
  logic i_mclk, i_rst, i_if_flag, i_ext_irq, i_ret_valid, i_ret_exc, i_ret_fp_exc, i_ret_fp_masked;
  logic i_ret_swint, i_ret_sstep, i_ret_bkpt, i_ret_task_switch, i_redirect_done, ext_req;
  logic o_ret_commit, o_ret_squash, o_evt_valid, o_evt_tsw_update, o_halt_fetch, o_fp_default, o_ext_ack;
  logic [PER_VEC_W-1:0]  i_ext_vec, i_ret_exc_vec, i_ret_swint_vec, i_dbg_vec, req_vec, o_evt_vector;
  logic [PER_ADDR_W-1:0] i_table_base, i_ret_pc, i_ret_next_pc, o_evt_desc_addr, o_evt_return_ptr;
  logic [3:0] dly;            // Redirect latency of the far side
  per_mode_t  i_mode;         // Operating mode
  per_kind_t  i_ret_exc_kind; // Exception kind
  per_class_t o_evt_class;    // Reported class
  per_src_t   o_evt_src;      // Reported source
  int error_cnt, checks, n, m;
  always #2 i_mclk = ~i_mclk;
  per_exception_reporter dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_mode(i_mode), .i_table_base(i_table_base),
    .i_if_flag(i_if_flag), .i_ext_irq(i_ext_irq), .i_ext_vec(i_ext_vec), .i_ret_valid(i_ret_valid),
    .i_ret_pc(i_ret_pc), .i_ret_next_pc(i_ret_next_pc), .i_ret_exc(i_ret_exc), .i_ret_exc_kind(i_ret_exc_kind),
    .i_ret_exc_vec(i_ret_exc_vec), .i_ret_fp_exc(i_ret_fp_exc), .i_ret_fp_masked(i_ret_fp_masked),
    .i_ret_swint(i_ret_swint), .i_ret_swint_vec(i_ret_swint_vec), .i_ret_sstep(i_ret_sstep),
    .i_ret_bkpt(i_ret_bkpt), .i_ret_task_switch(i_ret_task_switch), .i_dbg_vec(i_dbg_vec),
    .i_redirect_done(i_redirect_done), .o_ret_commit(o_ret_commit), .o_ret_squash(o_ret_squash),
    .o_evt_valid(o_evt_valid), .o_evt_class(o_evt_class), .o_evt_src(o_evt_src), .o_evt_vector(o_evt_vector),
    .o_evt_desc_addr(o_evt_desc_addr), .o_evt_return_ptr(o_evt_return_ptr), .o_evt_tsw_update(o_evt_tsw_update),
    .o_halt_fetch(o_halt_fetch), .o_fp_default(o_fp_default), .o_ext_ack(o_ext_ack));
  per_pipe_model u_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_halt_fetch(o_halt_fetch), .i_dly(dly),
    .i_ext_req(ext_req), .i_req_vec(req_vec), .o_redirect_done(i_redirect_done), .o_ext_irq(i_ext_irq),
    .o_ext_vec(i_ext_vec));
  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and close
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0b seen %0b", nm, exp, got);
    end
  endtask
  task automatic chk_val(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Entry address from mode-dependent entry size
  function automatic logic [63:0] desc(input logic [7:0] v);
    logic [2:0] sh;
    sh = (i_mode == PER_MODE_REAL) ? PER_SHIFT_REAL : (i_mode == PER_MODE_PROT) ? PER_SHIFT_PROT : PER_SHIFT_LONG;
    return BASE + ({56'h0, v} << sh);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Retire helpers: present, take, judge the delivered event
  task automatic pres(input logic [63:0] pc);
    @(posedge i_mclk);
    i_ret_valid   <= 1'b1;
    i_ret_pc      <= pc;
    i_ret_next_pc <= pc + 64'h4;
  endtask
  task automatic step(input logic ec, input logic es, input logic cs, input logic hold);
    #1;
    chk_bit("commit", ec, o_ret_commit);
    if (cs) chk_bit("squash", es, o_ret_squash);
    @(posedge i_mclk);
    {i_ret_exc, i_ret_fp_exc, i_ret_fp_masked, i_ret_swint, i_ret_sstep, i_ret_bkpt, i_ret_task_switch} <= 7'h00;
    i_ret_valid <= hold;
    #1;
  endtask
  task automatic evt(input per_class_t cls, input per_src_t src, input logic [7:0] vec,
                     input logic [63:0] ptr, input logic tsw);
    chk_bit("evt_valid", 1'b1, o_evt_valid);
    chk_val("class", cls, o_evt_class);
    chk_val("src", src, o_evt_src);
    chk_val("vector", vec, o_evt_vector);
    chk_val("desc_addr", desc(vec), o_evt_desc_addr);
    chk_val("return_ptr", ptr, o_evt_return_ptr);
    chk_bit("tsw_update", tsw, o_evt_tsw_update);
    chk_bit("halt", 1'b1, o_halt_fetch);
    chk_bit("held_commit", 1'b0, o_ret_commit);
    n = 0;
    while (i_redirect_done !== 1'b1 && n < 20) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    @(posedge i_mclk);
    i_ret_valid <= 1'b0;
    #1;
    chk_bit("halt_off", 1'b0, o_halt_fetch);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_fault();
    pres(64'h1000);
    i_ret_exc      <= 1'b1;
    i_ret_exc_kind <= PER_KIND_FAULT;
    i_ret_exc_vec  <= 8'h0e;
    step(1'b0, 1'b1, 1'b1, 1'b1);
    evt(PER_CLS_BEFORE, PER_SRC_EXC, 8'h0e, 64'h1000, 1'b0);
  endtask
  task automatic t_trap();
    pres(64'h1100);
    i_ret_exc      <= 1'b1;
    i_ret_exc_kind <= PER_KIND_TRAP;
    i_ret_exc_vec  <= 8'h04;
    dly            <= 4'h5;
    step(1'b1, 1'b0, 1'b1, 1'b1);
    evt(PER_CLS_AFTER, PER_SRC_EXC, 8'h04, 64'h1104, 1'b0);
  endtask
  task automatic t_abort();
    pres(64'h1200);
    i_ret_exc      <= 1'b1;
    i_ret_exc_kind <= PER_KIND_ABORT;
    i_ret_exc_vec  <= 8'h08;
    dly            <= 4'h0;
    step(1'b0, 1'b0, 1'b0, 1'b1);
    evt(PER_CLS_IMPRECISE, PER_SRC_EXC, 8'h08, 64'h1200, 1'b0);
  endtask
  task automatic t_debug();
    pres(64'h1300);
    i_ret_bkpt <= 1'b1;
    step(1'b0, 1'b1, 1'b1, 1'b1);
    evt(PER_CLS_BEFORE, PER_SRC_DEBUG, 8'h01, 64'h1300, 1'b0);
    pres(64'h1400);
    i_ret_sstep <= 1'b1;
    step(1'b1, 1'b0, 1'b1, 1'b1);
    evt(PER_CLS_AFTER, PER_SRC_DEBUG, 8'h01, 64'h1404, 1'b0);
  endtask
  task automatic t_fp();
    pres(64'h1500);
    i_ret_fp_exc    <= 1'b1;
    i_ret_fp_masked <= 1'b1;
    step(1'b1, 1'b0, 1'b1, 1'b0);
    chk_bit("fp_default", 1'b1, o_fp_default);
    chk_bit("no_event", 1'b0, o_evt_valid);
    pres(64'h1600);
    i_ret_fp_exc  <= 1'b1;
    i_ret_exc_vec <= 8'h10;
    step(1'b0, 1'b1, 1'b1, 1'b1);
    evt(PER_CLS_BEFORE, PER_SRC_EXC, 8'h10, 64'h1600, 1'b0);
  endtask
  task automatic t_swint();
    for (m = 0; m < 3; m++) begin
      pres(64'h2000 + 64'(m * 16));
      i_mode            <= per_mode_t'(m);
      i_ret_swint       <= 1'b1;
      i_ret_swint_vec   <= 8'h80 + 8'(m);
      i_ret_task_switch <= 1'b1;
      step(1'b1, 1'b0, 1'b1, 1'b1);
      evt(PER_CLS_AFTER, PER_SRC_SWINT, 8'h80 + 8'(m), 64'h2004 + 64'(m * 16), m != 2);
    end
  endtask
  task automatic t_ext();
    @(posedge i_mclk);
    ext_req <= 1'b1;
    req_vec <= 8'h41;
    @(posedge i_mclk);
    ext_req <= 1'b0;
    repeat (2) @(posedge i_mclk);
    pres(64'h3000);
    step(1'b1, 1'b0, 1'b1, 1'b0);
    chk_bit("ext_ack_masked", 1'b0, o_ext_ack);
    pres(64'h3010);
    i_if_flag <= 1'b1;
    step(1'b0, 1'b0, 1'b1, 1'b1);
    chk_bit("ext_ack", 1'b1, o_ext_ack);
    evt(PER_CLS_BEFORE, PER_SRC_EXT, 8'h41, 64'h3010, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    {i_mclk, i_if_flag, i_ret_valid, i_ret_exc, i_ret_fp_exc, i_ret_fp_masked, i_ret_swint} = 7'h00;
    {i_ret_sstep, i_ret_bkpt, i_ret_task_switch, ext_req} = 4'h0;
    {i_ret_exc_vec, i_ret_swint_vec, req_vec} = 24'h000000;
    {i_ret_pc, i_ret_next_pc} = 128'h0;
    i_dbg_vec      = 8'h01;
    i_table_base   = BASE;
    i_mode         = PER_MODE_PROT;
    i_ret_exc_kind = PER_KIND_FAULT;
    dly            = 4'h0;
    error_cnt      = 0;
    checks         = 0;
    i_rst          = 1'b1;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_fault();
    t_trap();
    t_abort();
    t_debug();
    t_fp();
    t_swint();
    t_ext();
    close_out();
  end
  initial begin
    #40000;
    error_cnt++;
    close_out();
  end
endmodule // test_precise_exception_reporter
`default_nettype wire
